// File: pkg/dpt_pkg.sv
// Package for the dual channel PWM timer block: register map, fields, reset values and types.
package dpt_pkg;

    localparam int NUM_CHAN = 2;

    // Register indices; the Wishbone byte address is four times the index.
    localparam logic [7:0] IDX_TIMER_ENABLES  = 8'hde;
    localparam logic [7:0] IDX_D_CONTROL      = 8'he1;
    localparam logic [7:0] IDX_D_PERIOD_LOW   = 8'he2;
    localparam logic [7:0] IDX_D_PERIOD_HIGH  = 8'he3;
    localparam logic [7:0] IDX_D_DUTY_LOW     = 8'he4;
    localparam logic [7:0] IDX_D_DUTY_HIGH    = 8'he5;
    localparam logic [7:0] IDX_D_COUNT_LOW    = 8'he6;
    localparam logic [7:0] IDX_D_COUNT_HIGH   = 8'he7;
    localparam logic [7:0] IDX_E_CONTROL      = 8'he9;
    localparam logic [7:0] IDX_E_PERIOD_LOW   = 8'hea;
    localparam logic [7:0] IDX_E_PERIOD_HIGH  = 8'heb;
    localparam logic [7:0] IDX_E_DUTY_LOW     = 8'hec;
    localparam logic [7:0] IDX_E_DUTY_HIGH    = 8'hed;
    localparam logic [7:0] IDX_E_COUNT_LOW    = 8'hee;
    localparam logic [7:0] IDX_E_COUNT_HIGH   = 8'hef;
    localparam logic [7:0] IDX_PIN_ENABLES    = 8'hd0;
    localparam logic [7:0] IDX_IRQ_STATUS     = 8'hd1;
    localparam logic [7:0] IDX_IRQ_MASK       = 8'hd2;
    // Distance between the same register of channel D and channel E.
    localparam logic [7:0] CHAN_STRIDE        = 8'h08;

    // Timer enable register bit positions.
    localparam int BIT_D_TIMER_ON = 0;
    localparam int BIT_E_TIMER_ON = 1;
    localparam int BIT_F_TIMER_ON = 2;
    localparam logic [2:0] TIMER_ENABLES_MASK = 3'h7;

    // Control register fields.
    localparam int BIT_PWM_ON     = 7;
    localparam int BIT_POLARITY   = 5;
    localparam int BIT_CLOCK_PICK = 3;
    localparam int PRESCALE_MSB   = 2;
    localparam logic [7:0] CONTROL_WRITE_MASK = 8'haf;

    // Pin enable register: bit 2c true pin, bit 2c+1 inverted pin of channel c.
    // Status and mask: bit 2c duty hit, bit 2c+1 period hit of channel c.
    localparam int BIT_DUTY_HIT   = 0;
    localparam int BIT_PERIOD_HIT = 1;

    localparam logic [7:0]  RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    typedef struct packed {
        logic       pwm_on;
        logic       polarity;
        logic       clock_pick;
        logic [2:0] prescale;
    } dpt_control_t;

    typedef struct packed {
        logic true_pin_output_enable;
        logic inverted_pin_output_enable;
    } dpt_pin_enable_t;

endpackage

// File: hw/dpt_pwm_timers.sv
// Dual channel 16-bit PWM timer block with a classic Wishbone register slave.
// Behaviour
// RULE1: Timer enable bits 2,1,0 switch channel F,E,D timers; no PWM while clear. Here there is no channel F: bit 2 is only stored.
// RULE2: Both pin enables and timer off: pins left to general I/O.
// RULE3: Both pin enables off, timer on: channel counts as a plain timer.
// RULE4: Pin enabled with timer off: pin taken and held at inactive level.
// RULE5: Timer on: each enabled pin carries the waveform, pins enabled independently.
// RULE6: Control bit 7 enables channel D PWM; resets to 0.
// RULE7: Control bit 5 zero gives high duty time, one gives low duty time.
// RULE8: Control bit 3 picks slow clock at 0, main clock at 1.
// RULE9: Prescale bits 2..0 divide by 1,2,4,8,16,64,128,256; reset 000.
// RULE10: Channel D period is read/write low and high bytes, reset zero.
// RULE11: Channel D duty is read/write low and high bytes, reset zero.
// RULE12: Writing channel D period low byte reloads period and duty into generator.
// RULE13: Channel D running count readable as read-only bytes, reset zero.
// RULE14: Channel E control register matches channel D layout and behaviour.
// RULE15: Channel E period and duty bytes; period low write reloads both.
// RULE16: Channel E running count readable as read-only bytes, reset zero.
// RULE17: Period match sets a sticky per-channel flag until software clears it.
// RULE18: Duty match sets a sticky per-channel flag until software clears it.
// RULE19: Count up from zero per tick; active below duty; restart after period.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps

module dpt_pwm_timers
    import dpt_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                slow_clock,
    input  wire logic                main_clock,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [9:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    output logic      [NUM_CHAN-1:0] true_wave_pin,
    output logic      [NUM_CHAN-1:0] true_wave_pin_oe_n,
    output logic      [NUM_CHAN-1:0] inverted_wave_pin,
    output logic      [NUM_CHAN-1:0] inverted_wave_pin_oe_n,
    output logic                     irq
);

    // Clock inputs are asynchronous to clk and pass two flip-flops before use.
    logic [1:0]            slow_sync;
    logic [1:0]            main_sync;
    logic                  slow_last;
    logic                  main_last;
    logic                  slow_edge;
    logic                  main_edge;

    logic [2:0]            timer_enables;
    dpt_control_t          control   [NUM_CHAN];
    logic [15:0]           period    [NUM_CHAN];
    logic [15:0]           duty      [NUM_CHAN];
    logic [15:0]           act_period[NUM_CHAN];
    logic [15:0]           act_duty  [NUM_CHAN];
    logic [15:0]           count     [NUM_CHAN];
    logic [7:0]            pre_count [NUM_CHAN];
    dpt_pin_enable_t       pin_en    [NUM_CHAN];
    logic [2*NUM_CHAN-1:0] status;
    logic [2*NUM_CHAN-1:0] mask;
    logic [2*NUM_CHAN-1:0] hit_event;

    logic                  bus_req;
    logic                  wr_take;
    logic                  rd_take;
    logic [7:0]            reg_idx;
    logic [7:0]            wr_byte;
    logic [7:0]            next_rd_byte;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_take = bus_req && wb_we_i && wb_sel_i[0];
    assign rd_take = bus_req && !wb_we_i;
    assign reg_idx = wb_adr_i[9:2];
    assign wr_byte = wb_dat_i[7:0];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            slow_sync <= 2'h0;
            main_sync <= 2'h0;
            slow_last <= 1'h0;
            main_last <= 1'h0;
        end
        else
        begin
            slow_sync <= {slow_sync[0], slow_clock};
            main_sync <= {main_sync[0], main_clock};
            slow_last <= slow_sync[1];
            main_last <= main_sync[1];
        end
    end

    assign slow_edge = slow_sync[1] && !slow_last;
    assign main_edge = main_sync[1] && !main_last;

    // Timer enables; channel F has no timer here, its bit is only stored.
    always_ff @(posedge clk)
    begin
        if (rst)
            timer_enables <= 3'h0; // see RULE1
        else if (wr_take && reg_idx == IDX_TIMER_ENABLES)
            timer_enables <= wr_byte[2:0] & TIMER_ENABLES_MASK; // see RULE1
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            mask <= '0;
        else if (wr_take && reg_idx == IDX_IRQ_MASK)
            mask <= wr_byte[2*NUM_CHAN-1:0];
    end

    // Status flags: a hit in the same cycle as the clearing read still sets its bit.
    always_ff @(posedge clk)
    begin
        if (rst)
            status <= '0;
        else if (rd_take && reg_idx == IDX_IRQ_STATUS)
            status <= hit_event; // see RULE17 see RULE18
        else
            status <= status | hit_event; // see RULE17 see RULE18
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            irq <= 1'h0;
        else
            irq <= |(status & mask);
    end

    genvar c;
    generate
        for (c = 0; c < NUM_CHAN; c++)
        begin : g_chan
            localparam logic [7:0] OFS = 8'(c) * CHAN_STRIDE;
            logic       ch_timer_on;
            logic       tick;
            logic [7:0] ratio_m1;
            logic       prescale_done;
            logic       reload;
            logic       pin_drive_true;
            logic       pin_drive_inv;
            logic       active_now;
            logic       level;

            assign ch_timer_on = timer_enables[c]; // see RULE1
            assign reload = wr_take && reg_idx == IDX_D_PERIOD_LOW + OFS; // see RULE12 see RULE15

            always_comb
            begin
                case (control[c].prescale) // see RULE9
                    3'h0:    ratio_m1 = 8'h00;
                    3'h1:    ratio_m1 = 8'h01;
                    3'h2:    ratio_m1 = 8'h03;
                    3'h3:    ratio_m1 = 8'h07;
                    3'h4:    ratio_m1 = 8'h0f;
                    3'h5:    ratio_m1 = 8'h3f;
                    3'h6:    ratio_m1 = 8'h7f;
                    default: ratio_m1 = 8'hff;
                endcase
            end

            // One source edge per clk at most, so the prescaler advances on edges only.
            assign tick = control[c].clock_pick ? main_edge : slow_edge; // see RULE8
            assign prescale_done = tick && pre_count[c] >= ratio_m1;

            always_ff @(posedge clk)
            begin
                if (rst)
                    control[c] <= '0; // see RULE6 see RULE14
                else if (wr_take && reg_idx == IDX_D_CONTROL + OFS)
                begin
                    control[c].pwm_on     <= wr_byte[BIT_PWM_ON];     // see RULE6 see RULE14
                    control[c].polarity   <= wr_byte[BIT_POLARITY];   // see RULE7
                    control[c].clock_pick <= wr_byte[BIT_CLOCK_PICK]; // see RULE8
                    control[c].prescale   <= wr_byte[PRESCALE_MSB:0]; // see RULE9
                end
            end

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    period[c] <= RESET_WORD; // see RULE10 see RULE15
                    duty[c]   <= RESET_WORD; // see RULE11 see RULE15
                end
                else if (wr_take)
                begin
                    if (reg_idx == IDX_D_PERIOD_LOW + OFS)
                        period[c][7:0] <= wr_byte;
                    if (reg_idx == IDX_D_PERIOD_HIGH + OFS)
                        period[c][15:8] <= wr_byte;
                    if (reg_idx == IDX_D_DUTY_LOW + OFS)
                        duty[c][7:0] <= wr_byte;
                    if (reg_idx == IDX_D_DUTY_HIGH + OFS)
                        duty[c][15:8] <= wr_byte;
                end
            end

            // The generator works from shadow copies, so half-written values never show.
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    act_period[c] <= RESET_WORD;
                    act_duty[c]   <= RESET_WORD;
                end
                else if (reload)
                begin
                    act_period[c] <= {period[c][15:8], wr_byte}; // see RULE12 see RULE15
                    act_duty[c]   <= duty[c];                    // see RULE12 see RULE15
                end
            end

            always_ff @(posedge clk)
            begin
                if (rst || !ch_timer_on)
                    pre_count[c] <= RESET_BYTE;
                else if (prescale_done)
                    pre_count[c] <= RESET_BYTE;
                else if (tick)
                    pre_count[c] <= pre_count[c] + 8'h01;
            end

            // Counting needs only the timer enable, so the channel also serves as a plain timer.
            always_ff @(posedge clk)
            begin
                if (rst || !ch_timer_on)
                    count[c] <= RESET_WORD; // see RULE1 see RULE3 see RULE13 see RULE16
                else if (prescale_done)
                begin
                    if (count[c] >= act_period[c])
                        count[c] <= RESET_WORD; // see RULE19
                    else
                        count[c] <= count[c] + 16'h0001; // see RULE19
                end
            end

            assign hit_event[2*c+BIT_PERIOD_HIT] = ch_timer_on && prescale_done
                                                   && count[c] == act_period[c]; // see RULE17
            assign hit_event[2*c+BIT_DUTY_HIT]   = ch_timer_on && prescale_done
                                                   && count[c] == act_duty[c];   // see RULE18

            always_ff @(posedge clk)
            begin
                if (rst)
                    pin_en[c] <= '0;
                else if (wr_take && reg_idx == IDX_PIN_ENABLES)
                    pin_en[c] <= {wr_byte[2*c], wr_byte[2*c+1]};
            end

            assign pin_drive_true = pin_en[c].true_pin_output_enable;     // see RULE5
            assign pin_drive_inv  = pin_en[c].inverted_pin_output_enable; // see RULE5
            assign active_now     = ch_timer_on && control[c].pwm_on && count[c] < act_duty[c]; // see RULE19
            // Active level is 1 for polarity 0; an idle channel sits at the inactive level.
            assign level          = active_now ^ control[c].polarity; // see RULE7 see RULE4

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    true_wave_pin[c]          <= 1'h0;
                    inverted_wave_pin[c]      <= 1'h0;
                    true_wave_pin_oe_n[c]     <= 1'h1; // see RULE2
                    inverted_wave_pin_oe_n[c] <= 1'h1; // see RULE2
                end
                else
                begin
                    true_wave_pin[c]          <= level;         // see RULE4 see RULE5
                    inverted_wave_pin[c]      <= !level;        // see RULE4 see RULE5
                    true_wave_pin_oe_n[c]     <= !pin_drive_true; // see RULE2 see RULE3 see RULE4
                    inverted_wave_pin_oe_n[c] <= !pin_drive_inv;  // see RULE2 see RULE3 see RULE4
                end
            end
        end
    endgenerate

    always_comb
    begin
        next_rd_byte = RESET_BYTE;
        case (reg_idx)
            IDX_TIMER_ENABLES: next_rd_byte = {5'h00, timer_enables};
            IDX_D_CONTROL:     next_rd_byte = {control[0].pwm_on, 1'h0, control[0].polarity, 1'h0,
                                               control[0].clock_pick, control[0].prescale};
            IDX_E_CONTROL:     next_rd_byte = {control[1].pwm_on, 1'h0, control[1].polarity, 1'h0,
                                               control[1].clock_pick, control[1].prescale};
            IDX_D_PERIOD_LOW:  next_rd_byte = period[0][7:0];
            IDX_D_PERIOD_HIGH: next_rd_byte = period[0][15:8];
            IDX_D_DUTY_LOW:    next_rd_byte = duty[0][7:0];
            IDX_D_DUTY_HIGH:   next_rd_byte = duty[0][15:8];
            IDX_D_COUNT_LOW:   next_rd_byte = count[0][7:0];  // see RULE13
            IDX_D_COUNT_HIGH:  next_rd_byte = count[0][15:8]; // see RULE13
            IDX_E_PERIOD_LOW:  next_rd_byte = period[1][7:0];
            IDX_E_PERIOD_HIGH: next_rd_byte = period[1][15:8];
            IDX_E_DUTY_LOW:    next_rd_byte = duty[1][7:0];
            IDX_E_DUTY_HIGH:   next_rd_byte = duty[1][15:8];
            IDX_E_COUNT_LOW:   next_rd_byte = count[1][7:0];  // see RULE16
            IDX_E_COUNT_HIGH:  next_rd_byte = count[1][15:8]; // see RULE16
            IDX_PIN_ENABLES:   next_rd_byte = {4'h0, pin_en[1].inverted_pin_output_enable,
                                               pin_en[1].true_pin_output_enable,
                                               pin_en[0].inverted_pin_output_enable,
                                               pin_en[0].true_pin_output_enable};
            IDX_IRQ_STATUS:    next_rd_byte = {4'h0, status};
            IDX_IRQ_MASK:      next_rd_byte = {4'h0, mask};
            default:           next_rd_byte = RESET_BYTE;
        endcase
    end

    // Every access, mapped or not, is answered one cycle after it is presented.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'h0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (rd_take)
                wb_dat_o <= {24'h000000, next_rd_byte};
        end
    end

endmodule

// File: verif/dpt_pwm_checker.sv
// Concurrent checks on the ports of the dual channel PWM timer block.
`timescale 1ns/1ps
module dpt_pwm_checker
    import dpt_pkg::*;
(
    input wire logic                clk,
    input wire logic                rst,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [9:0]          wb_adr_i,
    input wire logic [3:0]          wb_sel_i,
    input wire logic [31:0]         wb_dat_i,
    input wire logic [31:0]         wb_dat_o,
    input wire logic                wb_ack_o,
    input wire logic [NUM_CHAN-1:0] true_wave_pin,
    input wire logic [NUM_CHAN-1:0] true_wave_pin_oe_n,
    input wire logic [NUM_CHAN-1:0] inverted_wave_pin,
    input wire logic [NUM_CHAN-1:0] inverted_wave_pin_oe_n,
    input wire logic                irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic req;
    logic wr;
    logic d_on;
    logic d_pol;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i && wb_sel_i[0];
    // Shadow of the channel D enable and polarity, so the idle pin level can be judged.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            d_on <= 1'b0;
            d_pol <= 1'b0;
        end
        else if (wr && wb_adr_i[9:2] == IDX_TIMER_ENABLES)
            d_on <= wb_dat_i[BIT_D_TIMER_ON];
        else if (wr && wb_adr_i[9:2] == IDX_D_CONTROL)
            d_pol <= wb_dat_i[BIT_POLARITY];
    end
    ack_after_req_a: assert property (req |=> wb_ack_o) else $error("no ack after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    read_width_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits set");
    unmapped_zero_a: assert property (req && !wb_we_i && wb_adr_i[9:2] == 8'h00
        |=> wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
    pin_pair_a: assert property (!$past(rst) |-> inverted_wave_pin == ~true_wave_pin)
        else $error("pins not complementary");
    reset_quiet_a: assert property ($past(rst) |->
        &true_wave_pin_oe_n && &inverted_wave_pin_oe_n && !irq) else $error("outputs busy after reset");
    oe_cause_a: assert property (!$stable(true_wave_pin_oe_n) |-> $past(wr) || $past(wr, 2))
        else $error("pin enable moved without write");
    off_inactive_a: assert property ((!d_on && $stable(d_pol))[*3] |-> true_wave_pin[0] == d_pol)
        else $error("pin active with timer off");
    cover property ($rose(irq));
    cover property (d_on && $rose(true_wave_pin[0]));
    cover property (wr && wb_adr_i[9:2] == IDX_D_PERIOD_LOW);
endmodule

bind dpt_pwm_timers dpt_pwm_checker u_dpt_pwm_checker (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .true_wave_pin, .true_wave_pin_oe_n, .inverted_wave_pin,
    .inverted_wave_pin_oe_n, .irq);

// File: verif/dpt_pin_load.sv
// Loads on the wave pins; a released pad has no pull and floats.
`timescale 1ns/1ps
module dpt_pin_load
    import dpt_pkg::*;
(
    input  wire logic                clk,
    input  wire logic [NUM_CHAN-1:0] pin_true,
    input  wire logic [NUM_CHAN-1:0] oe_true_n,
    input  wire logic [NUM_CHAN-1:0] pin_inv,
    input  wire logic [NUM_CHAN-1:0] oe_inv_n,
    output logic      [NUM_CHAN-1:0] pad_true,
    output logic      [NUM_CHAN-1:0] pad_inv
);
    // A floating pad toggles every cycle so it can never pass for a driven level.
    logic flt = 1'b0;
    always @(posedge clk) flt <= ~flt;
    assign pad_true = (pin_true & ~oe_true_n) | ({NUM_CHAN{flt}} & oe_true_n);
    assign pad_inv = (pin_inv & ~oe_inv_n) | ({NUM_CHAN{flt}} & oe_inv_n);
endmodule

// File: verif/dpt_pwm_timers_tb.sv
// Self-checking testbench for the dual channel PWM timer block.
`timescale 1ns/1ps
module dpt_pwm_timers_tb
    import dpt_pkg::*;
();
    localparam logic [7:0] RW_IDX [11] = '{IDX_TIMER_ENABLES, IDX_D_CONTROL, IDX_D_PERIOD_LOW, IDX_D_PERIOD_HIGH,
        IDX_D_DUTY_LOW, IDX_D_DUTY_HIGH, IDX_E_CONTROL, IDX_E_PERIOD_LOW, IDX_E_PERIOD_HIGH, IDX_E_DUTY_LOW,
        IDX_E_DUTY_HIGH};
    localparam logic [7:0] RW_MASK [11] = '{8'h07, 8'haf, 8'hff, 8'hff, 8'hff, 8'hff, 8'haf, 8'hff, 8'hff,
        8'hff, 8'hff};
    localparam logic [7:0] CNT_IDX [4] = '{IDX_D_COUNT_LOW, IDX_D_COUNT_HIGH, IDX_E_COUNT_LOW, IDX_E_COUNT_HIGH};
    localparam int RATIO [8] = '{1, 2, 4, 8, 16, 64, 128, 256};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        slow_clock = 1'b0;
    logic        main_clock = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [9:0]  wb_adr_i = 10'h000;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [1:0]  true_wave_pin;
    logic [1:0]  true_wave_pin_oe_n;
    logic [1:0]  inverted_wave_pin;
    logic [1:0]  inverted_wave_pin_oe_n;
    logic        irq;
    logic [1:0]  pad_true;
    logic [1:0]  pad_inv;
    logic [31:0] exp_q [$];
    int          bad_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          p;
    logic [7:0]  d;

    dpt_pwm_timers u_dpt_pwm_timers (.clk, .rst, .slow_clock, .main_clock, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .true_wave_pin, .true_wave_pin_oe_n, .inverted_wave_pin,
        .inverted_wave_pin_oe_n, .irq);
    dpt_pin_load u_dpt_pin_load (.clk, .pin_true(true_wave_pin), .oe_true_n(true_wave_pin_oe_n),
        .pin_inv(inverted_wave_pin), .oe_inv_n(inverted_wave_pin_oe_n), .pad_true, .pad_inv);

    initial
    begin
        forever #5 clk = ~clk;
    end
    // Timer sources run at clk/8 (main) and clk/16 (slow), below clk/4, so the synchronisers see every edge.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        main_clock <= cycles[2];
        slow_clock <= cycles[3];
        if (cycles == 80000)
        begin
            bad_count++;
            stop_test();
        end
    end
    always @(posedge clk)
    begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            check("read data", exp_q.pop_front(), wb_dat_o);
    end

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // For a read, v is the expected byte and is noted for the monitor.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
        if (!w)
            exp_q.push_back({24'h000000, v});
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {a, 2'b00};
        wb_dat_i <= w ? {24'h000000, v} : 32'h00000000;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask
    task automatic setup(input int c, input logic [7:0] ctl);
        logic [7:0] b;
        b = 8'(c) * CHAN_STRIDE;
        bus(1'b1, IDX_D_CONTROL + b, ctl);
        bus(1'b1, IDX_D_PERIOD_HIGH + b, 8'h00);
        bus(1'b1, IDX_D_DUTY_HIGH + b, 8'h00);
        bus(1'b1, IDX_D_DUTY_LOW + b, 8'h01);
        bus(1'b1, IDX_D_PERIOD_LOW + b, 8'h03);
    endtask
    task automatic wave(input int c, input int n, input int eh, input int ei, input int er);
        int   ht;
        int   hi;
        int   rs;
        logic last;
        ht = 0;
        hi = 0;
        rs = 0;
        last = pad_true[c];
        repeat (n)
        begin
            @(posedge clk);
            ht += int'(pad_true[c]);
            hi += int'(pad_inv[c]);
            rs += int'(pad_true[c] && !last);
            last = pad_true[c];
        end
        check("true pad high cycles", 32'(eh), 32'(ht));
        check("inverted pad high cycles", 32'(ei), 32'(hi));
        if (er >= 0)
            check("true pad rising edges", 32'(er), 32'(rs));
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        void'($urandom(68111));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 11; i++)
            bus(1'b0, RW_IDX[i], 8'h00);
        bus(1'b0, 8'h00, 8'h00);
        for (int i = 0; i < 11; i++)
        begin
            d = 8'($urandom);
            bus(1'b1, RW_IDX[i], d);
            bus(1'b0, RW_IDX[i], d & RW_MASK[i]);
        end
        bus(1'b1, IDX_TIMER_ENABLES, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, CNT_IDX[i], 8'($urandom));
            bus(1'b0, CNT_IDX[i], 8'h00);
        end
        $display("test registers done");
        setup(0, 8'h88);
        for (int t = 0; t < 2; t++)
            for (int q = 0; q < 4; q++)
            begin
                bus(1'b1, IDX_PIN_ENABLES, 8'(q));
                bus(1'b1, IDX_TIMER_ENABLES, 8'(t));
                repeat (40) @(posedge clk);
                wave(0, 64, q[0] ? (t ? 16 : 0) : 32,
                     q[1] ? (t ? 48 : 64) : 32, -1);
            end
        bus(1'b1, IDX_D_DUTY_LOW, 8'h02);
        repeat (64) @(posedge clk);
        wave(0, 64, 16, 48, 2);
        bus(1'b1, IDX_D_PERIOD_LOW, 8'h03);
        repeat (64) @(posedge clk);
        wave(0, 64, 32, 32, 2);
        bus(1'b1, IDX_D_CONTROL, 8'h08);
        repeat (40) @(posedge clk);
        wave(0, 64, 0, 64, 0);
        $display("test pins and reload done");
        for (int k = 0; k < 8; k++)
        begin
            p = 32 * RATIO[k];
            setup(0, 8'h88 | 8'(k) | (k[0] ? 8'h20 : 8'h00));
            repeat (p) @(posedge clk);
            wave(0, 2 * p, k[0] ? 3 * p / 2 : p / 2, k[0] ? p / 2 : 3 * p / 2, 2);
        end
        bus(1'b1, IDX_PIN_ENABLES, 8'h0c);
        setup(1, 8'ha1);
        bus(1'b1, IDX_TIMER_ENABLES, 8'h03);
        repeat (128) @(posedge clk);
        wave(1, 256, 192, 64, 2);
        $display("test prescale and polarity done");
        bus(1'b1, IDX_TIMER_ENABLES, 8'h00);
        bus(1'b0, IDX_IRQ_STATUS, 8'h0f);
        // Channel D was left at the slowest prescale; without this no hit lands within the wait below.
        setup(0, 8'h88);
        bus(1'b1, IDX_IRQ_MASK, 8'h00);
        bus(1'b1, IDX_TIMER_ENABLES, 8'h01);
        repeat (64) @(posedge clk);
        check("irq masked", 32'h00000000, {31'h0, irq});
        bus(1'b1, IDX_TIMER_ENABLES, 8'h00);
        bus(1'b1, IDX_IRQ_MASK, 8'h02);
        repeat (3) @(posedge clk);
        check("irq raised", 32'h00000001, {31'h0, irq});
        bus(1'b0, IDX_IRQ_STATUS, 8'h03);
        repeat (3) @(posedge clk);
        check("irq cleared", 32'h00000000, {31'h0, irq});
        bus(1'b0, IDX_IRQ_STATUS, 8'h00);
        $display("test interrupts done");
        stop_test();
    end
endmodule
